// file: verilog/smart_card_parity_break_ctrl.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "smart_card_defs.svh"

module smart_card_parity_break_ctrl (
  input wire logic clk, // Master clock, 50 MHz
  input wire logic rst_n, // Sync reset, active low
  input wire logic ce, // Clock enable, freezes all state
  input wire logic [15:0] addr, // Register address
  input wire logic [7:0] wdata, // Register write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  input wire logic io_in, // Card I/O line level
  output logic io_out, // Card I/O drive value, always low
  output logic io_oe, // Card I/O pull low enable
  output logic card_clk, // Card clock output
  input wire logic tx_valid, // Character offered for sending
  input wire logic [7:0] tx_data, // Character to send
  output logic tx_ready, // Ready to take a character this cycle
  output logic tx_done, // Send finished, pulse
  output logic rx_valid, // Received character kept, pulse
  output logic [7:0] rx_data, // Received character
  output logic rx_parity_error, // Received character bad, pulse
  output logic card_break_seen // Card break detected, pulse
);

  smart_card_pkg::uart_state_type state;
  logic [5:0] div_field;
  logic [6:0] par_ctl;
  logic detect;
  logic direct;
  logic [1:0] brk_len_sel;
  logic spare;
  logic protocol_select;
  logic io_meta;
  logic io_sync;
  logic io_prev;
  logic tick;
  logic [5:0] applied;
  logic [8:0] htick;
  logic [4:0] hcnt;
  logic [4:0] pos;
  logic half_pulse;
  logic [8:0] rx_shift;
  logic brk_pending;
  logic [9:0] tx_frame;
  logic [7:0] tx_saved;
  logic brk_hold;
  logic drive_low;
  logic t0;
  logic rx_start;
  logic tx_load;
  logic rx_abort;
  logic rx_eval;
  logic rx_end;
  logic rx_brk_on;
  logic tx_sample;
  logic tx_end;
  logic resend;
  logic ts_dir;
  logic dir_eff;
  logic [7:0] rx_logical;
  logic rx_par_logical;
  logic par_bad;
  logic want_break;
  logic drop;
  logic [4:0] brk_half;
  logic [4:0] brk_end;
  localparam logic [7:0] char_ctl_reset = `CHAR_CTL_RESET;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction

  // Inverse convention: bits reversed and inverted; its own inverse
  function automatic logic [7:0] conv(input logic [7:0] d, input logic dir);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = ~d[7 - i];
    end
    conv = dir ? d : r;
  endfunction

  function automatic logic [9:0] build_frame(input logic [7:0] d, input logic dir,
                                             input logic inject);
    logic p;
    p = (^d) ^ inject;
    build_frame = {(dir ? p : ~p), conv(d, dir), 1'b0};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Card clock divider
  card_clock_divider u_div (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .div_field(div_field),
    .tick(tick),
    .applied(applied),
    .card_clk(card_clk)
  );

  ////////////////////////////////////////////////////////////////////
  // Decode and sequencing terms
  assign t0 = ~protocol_select;
  assign pos = hcnt + 5'd1;
  assign half_pulse = tick && (htick == `HALF_ETU_TICKS - 9'd1)
                      && (state != smart_card_pkg::st_idle);
  assign rx_start = (state == smart_card_pkg::st_idle) && io_prev && !io_sync;
  assign tx_ready = ce && (state == smart_card_pkg::st_idle) && !rx_start;
  assign tx_load = tx_ready && tx_valid;
  assign rx_abort = (state == smart_card_pkg::st_rx) && half_pulse
                    && (pos == `POS_START_CHECK) && io_sync;
  assign rx_eval = (state == smart_card_pkg::st_rx) && half_pulse && (pos == `POS_EVAL);
  assign rx_brk_on = (state == smart_card_pkg::st_rx) && half_pulse
                     && (pos == `POS_BREAK) && brk_pending;
  assign rx_end = (state == smart_card_pkg::st_rx) && half_pulse && (pos == brk_end);
  assign tx_sample = (state == smart_card_pkg::st_tx) && half_pulse
                     && (pos == `POS_BREAK_SAMPLE);
  assign tx_end = (state == smart_card_pkg::st_tx) && half_pulse && (pos == `POS_TX_END);
  assign resend = tx_end && brk_hold && par_ctl[`RESEND_BIT];

  always_comb
  begin
    case (brk_len_sel)
      2'b01: brk_half = `BRK_HALF_1P5ETU;
      2'b10: brk_half = `BRK_HALF_2ETU;
      default: brk_half = `BRK_HALF_1ETU;
    endcase
  end

  assign brk_end = brk_pending ? (`POS_BREAK + brk_half) : `POS_BREAK;

  // Received character evaluation
  assign ts_dir = (rx_shift[7:0] != `TS_INVERSE_RAW);
  assign dir_eff = detect ? ts_dir : direct;
  assign rx_logical = conv(rx_shift[7:0], dir_eff);
  assign rx_par_logical = dir_eff ? rx_shift[8] : ~rx_shift[8];
  assign par_bad = (~par_ctl[`PAR_DIS_BIT] & (^{rx_par_logical, rx_logical}))
                   | par_ctl[`FORCE_BIT];
  assign want_break = t0 && !par_ctl[`BREAK_GENERATE_DISABLE_DIS_BIT] && !par_ctl[`PAR_DIS_BIT]
                      && par_bad;
  assign drop = t0 && par_ctl[`DROP_BIT] && !par_ctl[`PAR_DIS_BIT] && par_bad;

  ////////////////////////////////////////////////////////////////////
  // Registers, one set for both protocols, T=0 and T=1
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_field <= `EXT_DIV_RESET;
      par_ctl <= `PAR_CTL_RESET;
      detect <= char_ctl_reset[`DETECT_BIT];
      direct <= char_ctl_reset[`DIRECT_BIT];
      brk_len_sel <= char_ctl_reset[`LEN_HI_BIT:`LEN_LO_BIT];
      spare <= char_ctl_reset[`SPARE_BIT];
      protocol_select <= `PROTO_RESET;
    end
    else if (ce)
    begin
      if (wr && hit(addr, `EXT_DIV_OFS))
        div_field <= wdata[5:0];
      if (wr && hit(addr, `PAR_CTL_OFS))
        par_ctl <= wdata[6:0];
      if (wr && hit(addr, `PROTO_OFS))
        protocol_select <= wdata[0];
      if (wr && hit(addr, `CHAR_CTL_OFS))
      begin
        brk_len_sel <= wdata[`LEN_HI_BIT:`LEN_LO_BIT];
        spare <= wdata[`SPARE_BIT];
      end
      if (wr && hit(addr, `CHAR_CTL_OFS))
        detect <= wdata[`DETECT_BIT];
      else if (rx_eval && detect)
        detect <= 1'b0;
      if (rx_eval && detect)
        direct <= ts_dir;
      else if (wr && hit(addr, `CHAR_CTL_OFS))
        direct <= wdata[`DIRECT_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (ce && rd)
    begin
      if (hit(addr, `EXT_DIV_OFS))
        rdata <= {2'b00, div_field};
      else if (hit(addr, `PAR_CTL_OFS))
        rdata <= {1'b0, par_ctl};
      else if (hit(addr, `CHAR_CTL_OFS))
        rdata <= {1'b0, detect, direct, brk_len_sel, spare, 2'b00};
      else if (hit(addr, `PROTO_OFS))
        rdata <= {7'h00, protocol_select};
      else
        rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // I/O line synchroniser
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      io_meta <= 1'b1;
      io_sync <= 1'b1;
      io_prev <= 1'b1;
    end
    else if (ce)
    begin
      io_meta <= io_in;
      io_sync <= io_meta;
      io_prev <= io_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer and half ETU timing
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= smart_card_pkg::st_idle;
      htick <= 9'd0;
      hcnt <= 5'd0;
    end
    else if (ce)
    begin
      if (state == smart_card_pkg::st_idle)
      begin
        htick <= 9'd0;
        hcnt <= 5'd0;
      end
      else
      begin
        if (tick)
          htick <= half_pulse ? 9'd0 : htick + 9'd1;
        if (half_pulse)
          hcnt <= resend ? 5'd0 : pos;
      end
      case (state)
        smart_card_pkg::st_idle:
        begin
          if (rx_start)
            state <= smart_card_pkg::st_rx;
          else if (tx_load)
            state <= smart_card_pkg::st_tx;
        end
        smart_card_pkg::st_rx:
        begin
          if (rx_abort || rx_end)
            state <= smart_card_pkg::st_idle;
        end
        smart_card_pkg::st_tx:
        begin
          if (tx_end && !resend)
            state <= smart_card_pkg::st_idle;
        end
        default:
          state <= smart_card_pkg::st_idle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receive path
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rx_shift <= 9'h000;
      brk_pending <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rx_parity_error <= 1'b0;
    end
    else if (ce)
    begin
      rx_valid <= 1'b0;
      rx_parity_error <= 1'b0;
      if (rx_start)
        brk_pending <= 1'b0;
      if ((state == smart_card_pkg::st_rx) && half_pulse && pos[0]
          && (pos >= `POS_FIRST_RX_BIT) && (pos <= `POS_LAST_RX_BIT))
        rx_shift <= {io_sync, rx_shift[8:1]};
      if (rx_eval)
      begin
        brk_pending <= want_break;
        rx_valid <= !drop;
        rx_data <= rx_logical;
        rx_parity_error <= par_bad;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Transmit path and card break detection
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_frame <= 10'h3ff;
      tx_saved <= 8'h00;
      brk_hold <= 1'b0;
      card_break_seen <= 1'b0;
      tx_done <= 1'b0;
    end
    else if (ce)
    begin
      card_break_seen <= 1'b0;
      tx_done <= tx_end && !resend;
      if (tx_load)
      begin
        tx_saved <= tx_data;
        tx_frame <= build_frame(tx_data, direct, par_ctl[`INJECT_BIT]);
        brk_hold <= 1'b0;
      end
      else if (resend)
      begin
        tx_frame <= build_frame(tx_saved, direct, par_ctl[`INJECT_BIT]);
        brk_hold <= 1'b0;
      end
      else if ((state == smart_card_pkg::st_tx) && half_pulse && !pos[0]
               && (pos < `POS_TX_RELEASE))
        tx_frame <= {1'b1, tx_frame[9:1]};
      if (tx_sample && !io_sync && t0 && !par_ctl[`BREAK_DETECT_DISABLE_DIS_BIT])
      begin
        brk_hold <= 1'b1;
        card_break_seen <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Open drain line drive
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      drive_low <= 1'b0;
    else if (ce)
    begin
      if (state == smart_card_pkg::st_tx)
        drive_low <= (hcnt < `POS_TX_RELEASE) && !tx_frame[0];
      else if (rx_end)
        drive_low <= 1'b0;
      else if (rx_brk_on)
        drive_low <= 1'b1;
      else if (state != smart_card_pkg::st_rx)
        drive_low <= 1'b0;
    end
  end

  assign io_oe = drive_low;
  assign io_out = 1'b0;

  ////////////////////////////////////////////////////////////////////
  // Checks
  logic [5:0] tick_gap;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tick_gap <= 6'h00;
    else if (ce)
      tick_gap <= tick ? 6'h00 : tick_gap + 6'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_div_period;
    (ce && tick) |-> (tick_gap == ((applied == 6'h00) ? 6'h01 : applied));
  endproperty
  a_div_period: assert property (p_div_period)
    else $error("card clock divider period wrong");

  property p_div_reset;
    $rose(rst_n) |-> (div_field == `EXT_DIV_RESET) && (applied == `EXT_DIV_RESET);
  endproperty
  a_div_reset: assert property (p_div_reset)
    else $error("divider field not at reset value");

  property p_div_glitchless;
    !(ce && tick) |=> $stable(applied);
  endproperty
  a_div_glitchless: assert property (p_div_glitchless)
    else $error("divider value changed mid period");

  property p_force_error;
    (ce && rx_eval && par_ctl[`FORCE_BIT]) |=> rx_parity_error;
  endproperty
  a_force_error: assert property (p_force_error)
    else $error("forced parity error not flagged");

  property p_break_time;
    (ce && rx_brk_on) |=> io_oe [*2];
  endproperty
  a_break_time: assert property (p_break_time)
    else $error("break not driven at 10.5 ETU");

  property p_no_break_disabled;
    ((state == smart_card_pkg::st_rx) && (par_ctl[`PAR_DIS_BIT] || protocol_select)
     && !brk_pending) |-> !io_oe;
  endproperty
  a_no_break_disabled: assert property (p_no_break_disabled)
    else $error("break driven with checking off or T=1");

  property p_drop;
    (ce && rx_eval && t0 && par_ctl[`DROP_BIT] && !par_ctl[`PAR_DIS_BIT] && par_bad)
      |=> !rx_valid;
  endproperty
  a_drop: assert property (p_drop)
    else $error("bad character not dropped");

  property p_tx_parity;
    (tx_load && direct) |=> (^tx_frame[9:1] == par_ctl[`INJECT_BIT]);
  endproperty
  a_tx_parity: assert property (p_tx_parity)
    else $error("transmit parity wrong");

  property p_resend;
    (ce && resend) |=> (state == smart_card_pkg::st_tx) && (hcnt == 5'd0);
  endproperty
  a_resend: assert property (p_resend)
    else $error("character not resent after card break");

  property p_sample_time;
    card_break_seen |-> $past(hcnt) == `POS_BREAK_SAMPLE - 5'd1;
  endproperty
  a_sample_time: assert property (p_sample_time)
    else $error("card break sampled at wrong time");

  property p_ts_clear;
    (ce && rx_eval && detect && !wr) |=> !detect && (direct == $past(ts_dir));
  endproperty
  a_ts_clear: assert property (p_ts_clear)
    else $error("TS flag not cleared or convention wrong");

  c_rx_break: cover property (ce && rx_brk_on);
  c_resend: cover property (ce && resend);
  c_ts_inverse: cover property (ce && rx_eval && detect && !ts_dir);
  c_tx_done: cover property (tx_done);

endmodule

// file: verilog/smart_card_defs.svh
`ifndef SMART_CARD_DEFS_SVH
`define SMART_CARD_DEFS_SVH

// Register offsets
`define EXT_DIV_OFS 16'hfe10
`define PAR_CTL_OFS 16'hfe11
`define CHAR_CTL_OFS 16'hfe12
`define PROTO_OFS 16'hfe20

// Reset values
`define EXT_DIV_RESET 6'h0c
`define PAR_CTL_RESET 7'h00
`define CHAR_CTL_RESET 8'h2c
`define PROTO_RESET 1'h0

// parity_break_control fields
`define PAR_DIS_BIT 6
`define BREAK_GENERATE_DISABLE_DIS_BIT 5
`define BREAK_DETECT_DISABLE_DIS_BIT 4
`define RESEND_BIT 3
`define DROP_BIT 2
`define INJECT_BIT 1
`define FORCE_BIT 0

// character_handling_control fields
`define DETECT_BIT 6
`define DIRECT_BIT 5
`define LEN_HI_BIT 4
`define LEN_LO_BIT 3
`define SPARE_BIT 2

// Half ETU length in divider ticks, then timing in half ETU steps from the start bit edge
`define HALF_ETU_TICKS 9'd372
`define POS_START_CHECK 5'd1
`define POS_LAST_RX_BIT 5'd19
`define POS_FIRST_RX_BIT 5'd3
`define POS_EVAL 5'd20
`define POS_BREAK 5'd21
`define POS_TX_RELEASE 5'd20
`define POS_BREAK_SAMPLE 5'd22
`define POS_TX_END 5'd24

// Break length in half ETUs
`define BRK_HALF_1ETU 5'd2
`define BRK_HALF_1P5ETU 5'd3
`define BRK_HALF_2ETU 5'd4

// Initial character patterns as seen on the line, LSB first
`define TS_INVERSE_RAW 8'h03

`endif

// file: verilog/smart_card_pkg.sv
package smart_card_pkg;

  typedef enum logic [1:0] {st_idle, st_rx, st_tx} uart_state_type;

endpackage

// file: verilog/card_clock_divider.sv
`timescale 1ns/1ps
`include "smart_card_defs.svh"

module card_clock_divider (
  input wire logic clk, // Master clock
  input wire logic rst_n, // Sync reset, active low
  input wire logic ce, // Clock enable
  input wire logic [5:0] div_field, // Programmed division value
  output logic tick, // ETU divider clock strobe
  output logic [5:0] applied, // Value in use by the divider
  output logic card_clk // Card clock, tick rate over two
);

  logic [5:0] cnt;
  logic [5:0] eff;

  assign eff = (applied == 6'h00) ? 6'h01 : applied;
  assign tick = (cnt == eff);

  ////////////////////////////////////////////////////////////////////
  // New value only taken at period end, so no short pulse
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt <= 6'h00;
      applied <= `EXT_DIV_RESET;
      card_clk <= 1'b0;
    end
    else if (ce)
    begin
      if (tick)
      begin
        cnt <= 6'h00;
        applied <= div_field;
        card_clk <= ~card_clk;
      end
      else
      begin
        cnt <= cnt + 6'h01;
      end
    end
  end

endmodule

// file: test/card_model.sv
`timescale 1ns/1ps
module card_model #(parameter int ETU = 1488) (
  input wire logic clk, // Master clock
  input wire logic line, // Resolved I/O line, pulled up
  input wire logic brk_req, // Break after received character
  output logic card_low, // Card pulls line low
  output logic got_valid, // Character sampled, pulse
  output logic [8:0] got // Parity and data as sampled
);
  logic sending = 1'b0;
  initial
  begin
    card_low = 1'b0;
    got_valid = 1'b0;
    got = '0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Start, eight bits LSB first, parity; bad flips parity
  task automatic send_char(input logic [7:0] b, input logic bad);
    logic [9:0] frame;
    frame = {(^b) ^ bad, b, 1'b0};
    sending = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      card_low <= ~frame[i];
      wait_clk(ETU);
    end
    card_low <= 1'b0;
    // Guard so the device break is not taken as a start bit
    wait_clk(3 * ETU);
    sending = 1'b0;
  endtask
  always
  begin
    @(posedge clk);
    if (!sending && line === 1'b0)
    begin
      wait_clk(ETU + ETU / 2 - 1);
      for (int i = 0; i < 9; i++)
      begin
        got[i] <= line;
        wait_clk(ETU);
      end
      got_valid <= 1'b1;
      card_low <= brk_req;
      wait_clk(1);
      got_valid <= 1'b0;
      wait_clk(ETU - 1);
      card_low <= 1'b0;
      while (line !== 1'b1) @(posedge clk);
    end
  end
endmodule

// file: test/smart_card_parity_break_ctrl_bench.sv
`timescale 1ns/1ps
module smart_card_parity_break_ctrl_bench;
  localparam int HALF = 744;
  localparam int QTR = 372;
  typedef struct {string name; logic [31:0] value;} note_type;
  note_type notes[$];
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int t_start = 0, t_fall = 0, t_oe = 0, t_tog = 0, t_rise = 0, meas_req = 0, meas_done = 0;
  logic clk = 0, rst_n = 0, ce = 1, wr = 0, rd = 0, tx_valid = 0, brk_req = 0;
  logic [15:0] addr = '0;
  logic [7:0] wdata = '0, tx_data = '0, b;
  logic [7:0] rdata, rx_data;
  logic io_out, io_oe, card_clk, tx_ready, tx_done, rx_valid, rx_parity_error, card_break_seen;
  logic card_low, got_valid;
  logic [8:0] got;
  logic rd_d = 0, prev_ck = 0, prev_oe = 0, prev_line = 1, armed = 0, tx_busy = 0, rx_mode = 0;
  logic [5:0] fl[3];
  wire line = ~(io_oe | card_low);

  smart_card_parity_break_ctrl dut (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .io_in(line), .io_out(io_out),
    .io_oe(io_oe), .card_clk(card_clk), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .tx_done(tx_done), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_parity_error(rx_parity_error), .card_break_seen(card_break_seen));
  card_model #(.ETU(2 * HALF)) card (.clk(clk), .line(line), .brk_req(brk_req),
    .card_low(card_low), .got_valid(got_valid), .got(got));

  initial forever #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic int quart(input int d);
    return (d + QTR / 2) / QTR;
  endfunction
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got_v);
    n_compared++;
    if (got_v !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got_v);
    end
  endtask
  task automatic check(input string name, input logic [31:0] got_v);
    note_type n;
    n = '{"nothing", 32'h0};
    if (notes.size() != 0) n = notes.pop_front();
    if (n.name != name)
    begin
      n_fail++;
      $display("[ERR] %s expected %s seen %h", name, n.name, got_v);
    end
    else cmp(name, n.value, got_v);
  endtask
  task automatic note(input string name, input logic [31:0] v);
    notes.push_back('{name, v});
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    rd <= 0;
    wr <= 1;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
    note("rdata", {24'h0, e});
    addr <= a;
    wr <= 0;
    rd <= 1;
    @(posedge clk);
  endtask
  task automatic bus_idle;
    wr <= 0;
    rd <= 0;
    @(posedge clk);
  endtask
  task automatic send_tx(input logic [7:0] v);
    tx_data <= v;
    tx_valid <= 1;
    @(posedge clk);
    tx_valid <= 0;
    #1 cmp("tx_ready", 0, tx_ready);
    for (int i = 0; i < 60 * HALF && tx_busy !== 1'b0; i++) @(posedge clk);
    wait_clk(4);
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    rd_d <= rd;
    prev_ck <= card_clk;
    prev_oe <= io_oe;
    prev_line <= line;
    if (rd_d) check("rdata", rdata);
    if (rst_n && card_clk !== prev_ck)
    begin
      t_tog <= cyc;
      if (cyc - t_tog < 2) cmp("clk_half_period", 1, 0);
    end
    if (card_clk === 1'b1 && prev_ck === 1'b0)
    begin
      t_rise <= cyc;
      if (meas_done != meas_req)
      begin
        if (armed) check("clk_period", cyc - t_rise);
        if (armed) meas_done <= meas_req;
        armed <= ~armed;
      end
    end
    if (tx_valid && tx_ready === 1'b1)
    begin
      t_start <= cyc;
      tx_busy <= 1;
    end
    if (card_break_seen === 1'b1) check("brk_seen", quart(cyc - t_start));
    if (tx_done === 1'b1)
    begin
      check("tx_done", quart(cyc - t_start));
      tx_busy <= 0;
    end
    if (got_valid === 1'b1) check("card_char", {23'h0, got});
    if (rx_parity_error === 1'b1) check("rx_perr", rx_valid);
    if (rx_valid === 1'b1)
    begin
      check("rx_data", rx_data);
      rx_mode <= 0;
    end
    if (!tx_busy && !rx_mode && prev_line === 1'b1 && line === 1'b0)
    begin
      rx_mode <= 1;
      t_fall <= cyc;
    end
    if (io_oe === 1'b1 && prev_oe === 1'b0) t_oe <= cyc;
    if (!tx_busy && io_oe === 1'b1 && prev_oe === 1'b0) check("brk_at", quart(cyc - t_fall));
    if (!tx_busy && io_oe === 1'b0 && prev_oe === 1'b1)
    begin
      check("brk_len", quart(cyc - t_oe));
      rx_mode <= 0;
    end
  end

  initial
  begin
    #(99000 * 20);
    n_fail++;
    $display("[ERR] watchdog expected end seen hang");
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hca48d374));
    wait_clk(8);
    rst_n <= 1;
    rd_reg(16'hfe10, 8'h0c);
    rd_reg(16'hfe11, 8'h00);
    rd_reg(16'hfe12, 8'h2c);
    rd_reg(16'hfe20, 8'h00);
    // Write with clock enable low must not land
    ce <= 0;
    wr_reg(16'hfe12, 8'h00);
    ce <= 1;
    rd_reg(16'hfe12, 8'h2c);
    wr_reg(16'hfe13, 8'hff);
    rd_reg(16'hfe13, 8'h00);
    b = $urandom;
    wr_reg(16'hfe11, b);
    rd_reg(16'hfe11, b & 8'h7f);
    wr_reg(16'hfe20, 8'h01);
    rd_reg(16'hfe20, 8'h01);
    wr_reg(16'hfe20, 8'h00);
    wr_reg(16'hfe11, 8'h00);
    bus_idle();
    wait_clk(60);
    note("clk_period", 26);
    meas_req <= meas_req + 1;
    wait_clk(80);
    fl = '{6'd1, 6'd2 + 6'($urandom % 8), 6'd0};
    foreach (fl[i])
    begin
      wr_reg(16'hfe10, {2'b11, fl[i]});
      rd_reg(16'hfe10, {2'b00, fl[i]});
      bus_idle();
      wait_clk(40);
      note("clk_period", 2 * ((fl[i] == 0 ? 1 : fl[i]) + 1));
      meas_req <= meas_req + 1;
      wait_clk(60);
    end
    // Card breaks the first copy only, device sends it again
    wr_reg(16'hfe11, 8'h08);
    bus_idle();
    b = $urandom;
    brk_req <= 1;
    note("card_char", {^b, b});
    note("brk_seen", 44);
    note("card_char", {^b, b});
    note("tx_done", 96);
    fork
      send_tx(b);
      begin
        wait_clk(23 * HALF);
        brk_req <= 0;
      end
    join
    // Odd parity inject; card break ignored with detection off
    wr_reg(16'hfe11, 8'h12);
    bus_idle();
    b = $urandom;
    brk_req <= 1;
    note("card_char", {~^b, b});
    note("tx_done", 48);
    send_tx(b);
    brk_req <= 0;
    // Bad parity from card: dropped, break 1.5 units long
    wr_reg(16'hfe11, 8'h04);
    bus_idle();
    note("rx_perr", 0);
    note("brk_at", 42);
    note("brk_len", 6);
    card.send_char($urandom, 1'b1);
    // Inverse initial character, forced error, checking off: kept, no break
    wr_reg(16'hfe11, 8'h41);
    wr_reg(16'hfe12, 8'h6c);
    bus_idle();
    note("rx_perr", 1);
    note("rx_data", 8'h3f);
    card.send_char(8'h03, 1'b0);
    rd_reg(16'hfe12, 8'h0c);
    bus_idle();
    wait_clk(20);
    cmp("notes_left", 0, notes.size());
    summarize();
  end
endmodule
